// ### rtl/nested_irq_priority_and_wait.sv
// Software priority registers, interrupt arbitration and WAIT/HALT mode control.
//
// Summary of operation
// - Reset sets all priority registers to ones.
// - Upper nibble of fourth register reads ones.
// - Pair encoding matches current priority bits.
// - Pair index rises per vector step down.
// - Writing level-0 code keeps that pair unchanged.
// - Reset, trap, top-level set both bits.
// - Top-level pair stored but ignored in arbitration.
// - Raised priority of running source re-enters it.
// - Enable, wait, halt instructions load level 0.
// - Disable and trap instructions load level 3.
// - Priority instructions inside routines change running level.
// - Fixed descending vector pairs from top source.
// - Only listed sources wake from halt.
// - Four registers at consecutive addresses.
// - Reset enters RUN, CPU at half rate.
// - Wait stops CPU only, peripherals run.
// - Entering WAIT enables every interrupt.
// - WAIT lasts until interrupt or reset.
// - Priority bits saved before servicing, restored by pop.
// - Each peripheral can be switched off by software.
// - Codes 10,01,00,11 are levels 0 to 3.
// - Highest level first, ties by fixed order.
// - Maskable taken only above running level.
// - Return restores saved priority bits.
//
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "nested_irq_consts.svh"
module nested_irq_priority_and_wait
   import nested_irq_pkg::*;
#(
   parameter int          NUM_SRC   = 11,
   parameter int          NUM_PERIPH = 8,
   parameter logic [10:0] HALT_WAKE = 11'h667
)(
   input  wire logic                  hclk,
   input  wire logic                  hresetn,
   input  wire logic                  hsel,
   input  wire logic [31:0]           haddr,
   input  wire logic [1:0]            htrans,
   input  wire logic                  hwrite,
   input  wire logic [2:0]            hsize,
   input  wire logic [31:0]           hwdata,
   input  wire logic                  hready,
   output logic                       hreadyout,
   output logic                       hresp,
   output logic [31:0]                hrdata,
   input  wire logic [NUM_SRC-1:0]    irq_req,
   input  wire logic                  instr_boundary,
   input  wire logic                  enable_irq_instr,
   input  wire logic                  disable_irq_instr,
   input  wire logic                  wait_for_irq_instr,
   input  wire logic                  halt_instr,
   input  wire logic                  trap_instr,
   input  wire logic                  irq_return_instr,
   input  wire logic                  pop_cc_instr,
   input  wire logic [1:0]            popped_prio,
   output logic [1:0]                 cur_prio,
   output logic                       irq_take,
   output logic [3:0]                 irq_index,
   output logic [15:0]                irq_vector,
   output logic [1:0]                 cc_save_prio,
   output logic                       cpu_clk_en,
   output logic [NUM_PERIPH-1:0]      periph_clk_en,
   output logic                       in_wait,
   output logic                       in_halt
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations.
   logic [7:0]            level_reg [4];     // Priority registers.
   logic [7:0]            periph_on;         // Peripheral enable bits.
   cpu_mode_t             mode;              // Current power mode.
   logic                  div_ph;            // CPU rate divider phase.
   logic                  wr_pend;           // Write data phase pending.
   logic [7:0]            wr_idx;            // Index latched at address phase.
   logic [1:0]            pair_code [14];    // Stored code per pair.
   logic [1:0]            pair_num [14];     // Numeric level per pair.
   logic                  found;             // A request may be taken.
   logic [3:0]            best_idx;          // Winning source.
   logic [1:0]            best_lvl;          // Winning numeric level.
   logic [1:0]            best_code;         // Winning priority code.
   logic                  acc_ok;            // Valid addressed access.
   logic [7:0]            acc_idx;           // Register index of access.
   logic [1:0]            run_num;           // Numeric running level.
   logic                  take_now;          // Interrupt taken this edge.
   logic                  trap_now;          // Trap taken this edge.
   logic                  instr_any;         // Priority instruction present.

   // Convert a priority code to a numeric level 0..3.
   function automatic logic [1:0] code_num(input logic [1:0] c);
      code_num = {~(c[1] ^ c[0]), c[0]};
   endfunction : code_num

   // The slave never stretches a transfer, so every access has zero wait states.
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign acc_ok    = hsel & hready & htrans[1] & (haddr[1:0] == 2'h0);
   assign acc_idx   = haddr[9:2];

   ////////////////////////////////////////////////////////////////////////////
   // Bus address phase: latch a pending write, prepare read data.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend <= 1'b0;
         wr_idx  <= 8'h00;
      end
      else if (hready)
      begin
         wr_pend <= acc_ok & hwrite;
         wr_idx  <= acc_idx;
      end
   end

   // Read data is registered at the address phase, so it stands in the data phase.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata <= 32'h0;
      else if (acc_ok && !hwrite)
      begin
         // Unmapped offsets read zero; all answers are OKAY.
         case (acc_idx)
            `IDX_LEVEL_0: hrdata <= {24'h0, level_reg[0]};
            `IDX_LEVEL_1: hrdata <= {24'h0, level_reg[1]};
            `IDX_LEVEL_2: hrdata <= {24'h0, level_reg[2]};
            `IDX_LEVEL_3: hrdata <= {24'h0, `LEVEL3_RO, level_reg[3][3:0]};
            `IDX_PERIPH:  hrdata <= {24'h0, periph_on};
            // Status holds the power mode above the running priority bits.
            `IDX_STATUS:  hrdata <= {28'h0, mode, cur_prio};
            default:      hrdata <= 32'h0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Priority registers, one filtered pair at a time.
   // The read-only nibble of the fourth register is forced to ones every cycle, so writes there fall away.
   genvar g;
   generate
      for (g = 0; g < 16; g++)
      begin : g_pair
         localparam int R = g / 4;
         localparam int B = (g % 4) * 2;
         always_ff @(posedge hclk or negedge hresetn)
         begin
            if (!hresetn)
               level_reg[R][B +: 2] <= 2'(`LEVEL_RST >> B);
            else if (R == 3 && B >= 4)
               level_reg[R][B +: 2] <= 2'h3;
            else if (wr_pend && wr_idx == `IDX_LEVEL_0 + 8'(R)
                     && hwdata[B +: 2] != `PRIO_LVL0)
               level_reg[R][B +: 2] <= hwdata[B +: 2];
         end
         if (g < 14)
         begin : g_code
            assign pair_code[g] = level_reg[R][B +: 2];
            assign pair_num[g]  = code_num(level_reg[R][B +: 2]);
         end
      end
   endgenerate

   // Peripheral switch-off register; a zero bit stops that peripheral.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         periph_on <= `PERIPH_RST;
      else if (wr_pend && wr_idx == `IDX_PERIPH)
         periph_on <= hwdata[7:0];
   end

   ////////////////////////////////////////////////////////////////////////////
   // Arbitration: highest level wins, lower index wins a tie.
   // The loop runs downwards so that, on equal levels, the lower index is the one kept.
   assign run_num = code_num(cur_prio);
   always_comb
   begin
      found     = 1'b0;
      best_idx  = 4'h0;
      best_lvl  = 2'h0;
      best_code = 2'h0;
      for (int i = NUM_SRC - 1; i >= 0; i--)
      begin
         logic [1:0] lv;
         logic [1:0] cd;
         // Source 0 is the top-level request: its pair is ignored.
         lv = (i == 0) ? 2'h3 : pair_num[i];
         cd = (i == 0) ? `PRIO_LVL3 : pair_code[i];
         // Non-maskable goes through level 3; maskable needs a higher level.
         if (irq_req[i] && ((i == 0) || lv > run_num)
             && (mode != MODE_HALT || HALT_WAKE[i])
             && (!found || lv >= best_lvl))
         begin
            found     = 1'b1;
            best_idx  = 4'(i);
            best_lvl  = lv;
            best_code = cd;
         end
      end
   end

   assign instr_any = enable_irq_instr | disable_irq_instr | wait_for_irq_instr
                    | halt_instr | irq_return_instr | pop_cc_instr;
   assign trap_now  = trap_instr & instr_boundary & (mode == MODE_RUN) & ~irq_req[0];
   // A stopped core takes interrupts at once; a running one at a boundary.
   // A source drops its request only when it sees the take pulse, so nothing is taken while
   // that pulse stands; otherwise a top-level request would be serviced twice.
   assign take_now  = found & ~instr_any & ~irq_take & (instr_boundary | mode != MODE_RUN);

   ////////////////////////////////////////////////////////////////////////////
   // Current priority bits of the condition codes.
   // The order of the branches ranks events that fall in the same cycle.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         cur_prio <= `PRIO_LVL3;
      else if (take_now)
         cur_prio <= best_code; // re-entry follows from a raised stored level.
      else if (trap_now || disable_irq_instr)
         cur_prio <= `PRIO_LVL3;
      else if (enable_irq_instr || halt_instr || wait_for_irq_instr)
         cur_prio <= `PRIO_LVL0;
      else if (irq_return_instr || pop_cc_instr)
         cur_prio <= popped_prio;
   end

   // Service pulse with the vector and the priority pushed on the stack.
   // Source i sits one two-byte vector step below source i-1.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         irq_take     <= 1'b0;
         irq_index    <= 4'h0;
         irq_vector   <= `VEC_TOP;
         cc_save_prio <= `PRIO_LVL3;
      end
      else
      begin
         irq_take <= take_now | trap_now;
         if (take_now || trap_now)
         begin
            irq_index    <= take_now ? best_idx : 4'hF;
            irq_vector   <= take_now ? `VEC_TOP - {11'h0, best_idx, 1'b0} : `VEC_TRAP;
            cc_save_prio <= cur_prio;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Power mode: WAIT and HALT end when an interrupt is taken.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         mode <= MODE_RUN;
      else
      begin
         case (mode)
            MODE_RUN:
            begin
               if (wait_for_irq_instr)
                  mode <= MODE_WAIT;
               else if (halt_instr)
                  mode <= MODE_HALT;
            end
            MODE_WAIT,
            MODE_HALT:
            begin
               if (take_now)
                  mode <= MODE_RUN;
            end
            default:
               mode <= MODE_RUN;
         endcase
      end
   end

   // Divide by two for the CPU rate enable.
   // The enable runs from reset on, so the core starts in RUN at half rate.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         div_ph <= 1'b0;
      else
         div_ph <= ~div_ph;
   end

   // WAIT stops only the CPU; HALT stops everything.
   assign cpu_clk_en    = div_ph & (mode == MODE_RUN);
   assign periph_clk_en = (mode == MODE_HALT) ? '0 : {NUM_PERIPH{div_ph}} & periph_on;
   assign in_wait       = (mode == MODE_WAIT);
   assign in_halt       = (mode == MODE_HALT);

   ////////////////////////////////////////////////////////////////////////////
   // Checks.
   // Each antecedent but that of AST_WAIT_ENTRY, which keeps disable and trap, leaves out the events that outrank it in the same cycle.
   AST_RO_NIBBLE: assert property (@(posedge hclk) disable iff (!hresetn)
      level_reg[3][7:4] == `LEVEL3_RO) else $error("upper nibble not ones");

   AST_LVL0_KEPT: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_pend && wr_idx == `IDX_LEVEL_0 && hwdata[1:0] == `PRIO_LVL0
      |=> level_reg[0][1:0] == $past(level_reg[0][1:0])) else $error("level 0 written");

   AST_LEVEL_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_pend && wr_idx == `IDX_LEVEL_1 && hwdata[1:0] != `PRIO_LVL0
      |=> level_reg[1][1:0] == $past(hwdata[1:0])) else $error("level write lost");

   AST_ENABLE: assert property (@(posedge hclk) disable iff (!hresetn)
      enable_irq_instr && !take_now && !trap_now && !disable_irq_instr
      |=> cur_prio == `PRIO_LVL0) else $error("enable did not load level 0");

   AST_HALT_ENTRY: assert property (@(posedge hclk) disable iff (!hresetn)
      mode == MODE_RUN && halt_instr && !wait_for_irq_instr && !disable_irq_instr && !trap_now
      |=> in_halt && cur_prio == `PRIO_LVL0) else $error("halt entry wrong");

   AST_DISABLE: assert property (@(posedge hclk) disable iff (!hresetn)
      (disable_irq_instr || trap_now) && !take_now
      |=> cur_prio == `PRIO_LVL3) else $error("disable did not load level 3");

   AST_TRAP_VEC: assert property (@(posedge hclk) disable iff (!hresetn)
      trap_now && !take_now |=> irq_take && irq_index == 4'hF && irq_vector == `VEC_TRAP)
      else $error("trap service wrong");

   AST_WAIT_ENTRY: assert property (@(posedge hclk) disable iff (!hresetn)
      mode == MODE_RUN && wait_for_irq_instr && !take_now
      |=> in_wait && cur_prio == `PRIO_LVL0) else $error("wait entry wrong");

   AST_WAIT_CPU: assert property (@(posedge hclk) disable iff (!hresetn)
      in_wait |-> !cpu_clk_en && periph_clk_en == ({NUM_PERIPH{div_ph}} & periph_on))
      else $error("wait clocks wrong");

   AST_HALT_STOP: assert property (@(posedge hclk) disable iff (!hresetn)
      in_halt |-> periph_clk_en == '0 && !cpu_clk_en) else $error("clocks run in halt");

   AST_WAIT_EXIT: assert property (@(posedge hclk) disable iff (!hresetn)
      in_wait && take_now |=> !in_wait && irq_take) else $error("wait not left on interrupt");

   AST_ABOVE: assert property (@(posedge hclk) disable iff (!hresetn)
      take_now && best_idx != 4'h0 |-> best_lvl > run_num ##1 irq_take)
      else $error("taken at or below running level");

   AST_PUSH: assert property (@(posedge hclk) disable iff (!hresetn)
      take_now |=> cc_save_prio == $past(cur_prio) && cur_prio == $past(best_code))
      else $error("saved priority wrong");

   AST_RETURN: assert property (@(posedge hclk) disable iff (!hresetn)
      (irq_return_instr || pop_cc_instr) && !take_now && !trap_now && !disable_irq_instr
      && !enable_irq_instr && !halt_instr && !wait_for_irq_instr
      |=> cur_prio == $past(popped_prio)) else $error("return did not restore priority");

   AST_TOP_LEVEL: assert property (@(posedge hclk) disable iff (!hresetn)
      take_now && best_idx == 4'h0 |=> cur_prio == `PRIO_LVL3 && irq_vector == `VEC_TOP)
      else $error("top-level service wrong");

   AST_TOP_ONCE: assert property (@(posedge hclk) disable iff (!hresetn)
      irq_take && irq_index == 4'h0 |=> !(irq_take && irq_index == 4'h0))
      else $error("top-level request serviced twice");

   AST_HALT_WAKE: assert property (@(posedge hclk) disable iff (!hresetn)
      in_halt && take_now |-> HALT_WAKE[best_idx]) else $error("halt woken by wrong source");

   AST_DIV: assert property (@(posedge hclk) disable iff (!hresetn)
      cpu_clk_en |=> !cpu_clk_en) else $error("cpu rate not halved");

   AST_RUN_CPU: assert property (@(posedge hclk) disable iff (!hresetn)
      mode == MODE_RUN && !cpu_clk_en && !wait_for_irq_instr && !halt_instr
      |=> cpu_clk_en) else $error("cpu rate enable missing in run");

   COV_NEST: cover property (@(posedge hclk) disable iff (!hresetn)
      irq_take ##[1:20] irq_take && cc_save_prio != `PRIO_LVL0);
   COV_WAIT_EXIT: cover property (@(posedge hclk) disable iff (!hresetn)
      in_wait ##1 !in_wait);
   COV_HALT_EXIT: cover property (@(posedge hclk) disable iff (!hresetn)
      in_halt ##1 !in_halt);
   COV_TRAP: cover property (@(posedge hclk) disable iff (!hresetn) trap_now);
   COV_TOP: cover property (@(posedge hclk) disable iff (!hresetn) irq_take && irq_index == 4'h0);

endmodule : nested_irq_priority_and_wait
`default_nettype wire

// ### rtl/nested_irq_consts.svh
// Offsets, field positions, reset values and timing counts of the nested interrupt priority block.
`ifndef NESTED_IRQ_CONSTS_SVH
`define NESTED_IRQ_CONSTS_SVH
// Register indices as printed; the byte address is four times the index.
`define IDX_LEVEL_0   8'h2C
`define IDX_LEVEL_1   8'h2D
`define IDX_LEVEL_2   8'h2E
`define IDX_LEVEL_3   8'h2F
`define IDX_PERIPH    8'h30
`define IDX_STATUS    8'h31
// Reset values.
`define LEVEL_RST     8'hFF
`define PERIPH_RST    8'hFF
`define LEVEL3_RO     4'hF
// Priority codes, high bit then low bit.
`define PRIO_LVL0     2'h2
`define PRIO_LVL3     2'h3
// Vector addresses.
`define VEC_TOP       16'hFFFA
`define VEC_TRAP      16'hFFFC
// Main oscillator divided by two gives the CPU rate.
`define CPU_DIV       2
`endif

// ### rtl/nested_irq_pkg.sv
// Types shared by the nested interrupt priority block.
package nested_irq_pkg;
   // Power mode of the core.
   typedef enum logic [1:0] {MODE_RUN, MODE_WAIT, MODE_HALT} cpu_mode_t;
endpackage : nested_irq_pkg

// ### dv/core_source_model.sv
// Model of the core boundary and the interrupt-raising sources that face the priority block.
`timescale 1ns/10ps
`default_nettype none
module core_source_model
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        slow,           // High lets instructions stretch at random.
   input  wire logic [10:0] raise,          // One-cycle request pulses from the bench.
   input  wire logic        irq_take,       // Take pulse from the block.
   input  wire logic [3:0]  irq_index,      // Source that was taken.
   output logic      [10:0] irq_req,        // Latched level requests.
   output logic             instr_boundary  // Core sits at the end of an instruction.
);
   ////////////////////////////////////////////////////////////////////////////////
   // A request stays latched until the block reports it taken, so a refused one stays pending.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         irq_req        <= 11'h000;
         instr_boundary <= 1'b1;
      end
      else
      begin
         irq_req        <= (irq_req & ~((irq_take && irq_index < 4'hB) ? 11'h001 << irq_index : 11'h000)) | raise;
         instr_boundary <= slow ? ($urandom_range(1, 0) == 1) : 1'b1;
      end
   end
endmodule : core_source_model
`default_nettype wire

// ### dv/nested_irq_priority_and_wait_test.sv
// Self-checking bench for the nested interrupt priority block.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin error_cnt++; $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module nested_irq_priority_and_wait_test;
   ////////////////////////////////////////////////////////////////////////////////
   // Bus, core and source signals; every input has a value at time zero.
   logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b1, hwrite = 1'b0, hready, hreadyout;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
   logic [1:0]  htrans = 2'h0, popped_prio = 2'h2, cur_prio, cc_save_prio;
   logic [2:0]  hsize = 3'h2;
   logic [10:0] irq_req, raise = 11'h000, m;
   logic [6:0]  instr = 7'h00;  // Enable, disable, wait, halt, trap, return, pop.
   logic        slow = 1'b0, instr_boundary, irq_take, cpu_clk_en, in_wait, in_halt, hresp;
   logic [7:0]  periph_clk_en, pe;
   logic [3:0]  irq_index;
   logic [15:0] irq_vector;
   int          code [16];      // Stored pair codes as software expects them.
   int          error_cnt = 0, n_compared = 0, cyc = 0, best, r;
   assign hready = hreadyout;
   always #5 hclk = ~hclk;
   nested_irq_priority_and_wait dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq_req(irq_req), .instr_boundary(instr_boundary),
      .enable_irq_instr(instr[0]), .disable_irq_instr(instr[1]), .wait_for_irq_instr(instr[2]),
      .halt_instr(instr[3]), .trap_instr(instr[4]), .irq_return_instr(instr[5]), .pop_cc_instr(instr[6]),
      .popped_prio(popped_prio), .cur_prio(cur_prio), .irq_take(irq_take), .irq_index(irq_index),
      .irq_vector(irq_vector), .cc_save_prio(cc_save_prio), .cpu_clk_en(cpu_clk_en),
      .periph_clk_en(periph_clk_en),
      .in_wait(in_wait), .in_halt(in_halt));
   core_source_model partner (.hclk(hclk), .hresetn(hresetn), .slow(slow), .raise(raise),
      .irq_take(irq_take), .irq_index(irq_index), .irq_req(irq_req), .instr_boundary(instr_boundary));
   ////////////////////////////////////////////////////////////////////////////////
   // Level of a pair code, and the byte that a register should read back.
   function automatic int lvl(input int c);
      return (c == 2) ? 0 : (c == 1) ? 1 : (c == 0) ? 2 : 3;
   endfunction : lvl
   function automatic logic [31:0] pack(input int rg);
      pack = 32'h0;
      for (int p = 0; p < 4; p++) pack[2*p +: 2] = 2'(code[4*rg+p]);
   endfunction : pack
   // One single AHB-Lite transfer; read data are taken at the data phase's closing edge.
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
      @(posedge hclk);
      htrans <= 2'h2;
      haddr  <= a;
      hwrite <= wr;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      q = hrdata;
   endtask : bus
   // Write a level register and update the expected pairs, dropping level-0 codes and fixed bits.
   task automatic wr_lvl(input int rg, input logic [7:0] d);
      bus(1'b1, 32'hB0 + 32'(4*rg), {24'h0, d});
      for (int p = 0; p < 4; p++) if (d[2*p +: 2] != 2'h2 && 4*rg+p < 14) code[4*rg+p] = d[2*p +: 2];
   endtask : wr_lvl
   task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      `CHK("hrdata", e, q)
   endtask : rd_chk
   // One-cycle instruction pulse; returns in the low phase after the block has seen it.
   task automatic ins(input int b);
      @(posedge hclk);
      instr <= 7'(1 << b);
      @(posedge hclk);
      instr <= 7'h00;
      @(negedge hclk);
   endtask : ins
   task automatic rs(input logic [10:0] mk);
      @(posedge hclk);
      raise <= mk;
      @(posedge hclk);
      raise <= 11'h000;
   endtask : rs
   // Wait a bounded time for a take, then check whether it came and what it carried.
   task automatic take(input int n, input logic ex, input logic [3:0] i);
      int          k;
      logic [15:0] v;
      k = 0;
      v = (i == 4'hF) ? 16'hFFFC : 16'hFFFA - {11'h0, i, 1'b0};
      while (irq_take !== 1'b1 && k < n)
      begin
         @(negedge hclk);
         k++;
      end
      `CHK("irq_take", ex, irq_take)
      if (ex)
      begin
         `CHK("irq_index", i, irq_index)
         `CHK("irq_vector", v, irq_vector)
      end
      @(negedge hclk);
   endtask : take
   task automatic give_verdict();
      if (error_cnt == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : give_verdict
   ////////////////////////////////////////////////////////////////////////////////
   // A hang is cut short here and reported as a mismatch.
   always @(posedge hclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         error_cnt++;
         give_verdict();
      end
   end
   // Main sequence: registers, arbitration, re-entry, masking, traps, WAIT and HALT.
   initial
   begin
      for (int i = 0; i < 16; i++) code[i] = 3;
      void'($urandom(11353));
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      for (int i = 0; i < 4; i++) rd_chk(32'hB0 + 32'(4*i), 32'hFF);
      rd_chk(32'h100, 32'h0);
      rd_chk(32'hC0, 32'hFF);
      bus(1'b1, 32'hC0, 32'h5A);
      rd_chk(32'hC0, 32'h5A);
      `CHK("hresp", 1'b0, hresp)
      wr_lvl(0, 8'hCF);
      wr_lvl(0, 8'h64);
      rd_chk(32'hB0, 32'h44);
      repeat (12)
      begin
         r = $urandom_range(3, 0);
         wr_lvl(r, 8'($urandom));
         rd_chk(32'hB0 + 32'(4*r), pack(r));
      end
      ins(0);
      `CHK("cur_prio", 2'h2, cur_prio)
      rd_chk(32'hC4, 32'h2);
      slow <= 1'b1;
      repeat (6)
      begin
         m = 11'($urandom) & 11'h7FE;
         rs(m);
         while (m != 11'h000)
         begin
            best = 0;
            for (int i = 1; i < 11; i++) if (m[i] && (best == 0 || lvl(code[i]) > lvl(code[best]))) best = i;
            take(40, 1'b1, 4'(best));
            `CHK("cur_prio", 2'(code[best]), cur_prio)
            `CHK("cc_save_prio", 2'h2, cc_save_prio)
            m[best] = 1'b0;
            ins(5);
            `CHK("cur_prio", 2'h2, cur_prio)
         end
      end
      slow <= 1'b0;
      wr_lvl(0, 8'h7F);
      rs(11'h008);
      take(20, 1'b1, 4'h3);
      rs(11'h008);
      take(10, 1'b0, 4'h0);
      wr_lvl(0, 8'h3F);
      take(20, 1'b1, 4'h3);
      `CHK("cur_prio", 2'h0, cur_prio)
      ins(5);
      ins(1);
      `CHK("cur_prio", 2'h3, cur_prio)
      rs(11'h008);
      take(10, 1'b0, 4'h0);
      ins(0);
      take(20, 1'b1, 4'h3);
      ins(5);
      ins(4);
      take(20, 1'b1, 4'hF);
      `CHK("cur_prio", 2'h3, cur_prio)
      ins(5);
      wr_lvl(0, 8'h3D);
      rd_chk(32'hB0, 32'h3D);
      ins(1);
      rs(11'h001);
      take(20, 1'b1, 4'h0);
      `CHK("cur_prio", 2'h3, cur_prio)
      repeat (4) @(negedge hclk);
      ins(5);
      wr_lvl(1, 8'hFF);
      ins(2);
      `CHK("in_wait", 1'b1, in_wait)
      `CHK("cur_prio", 2'h2, cur_prio)
      `CHK("cpu_clk_en", 1'b0, cpu_clk_en)
      pe = periph_clk_en;
      @(negedge hclk);
      `CHK("periph_clk_en", 8'h5A, pe | periph_clk_en)
      rd_chk(32'hC4, 32'h6);
      rs(11'h020);
      take(20, 1'b1, 4'h5);
      `CHK("in_wait", 1'b0, in_wait)
      ins(5);
      ins(3);
      `CHK("in_halt", 1'b1, in_halt)
      `CHK("periph_clk_en", 8'h00, periph_clk_en)
      rd_chk(32'hC4, 32'hA);
      `CHK("cur_prio", 2'h2, cur_prio)
      rs(11'h008);
      take(10, 1'b0, 4'h0);
      rs(11'h020);
      take(20, 1'b1, 4'h5);
      ins(5);
      take(20, 1'b1, 4'h3);
      ins(5);
      give_verdict();
   end
endmodule : nested_irq_priority_and_wait_test
`default_nettype wire
